// File: hdl/mcce_map.svh
`ifndef MCCE_MAP_SVH
`define MCCE_MAP_SVH
`define MCCE_OFF_CTRL 12'h000
`define MCCE_OFF_CYCLES 12'h004
`define MCCE_OFF_SETTLE 12'h008
`define MCCE_OFF_STATUS 12'h00C
`define MCCE_OFF_MASK 12'h010
`define MCCE_OFF_DCOFF 12'h020
`define MCCE_OFF_GAIN 12'h030
`define MCCE_OFF_ACOFF 12'h040
`define MCCE_CHAN_FIELD 12'hFF3
`define MCCE_CTRL_CMD_LSB 0
`define MCCE_CTRL_CH_LSB 4
`define MCCE_CTRL_GO_BIT 8
`define MCCE_ST_BUSY_BIT 16
`define MCCE_RST_CYCLES 24'h000FA0
`define MCCE_RST_SETTLE 24'h000080
`define MCCE_RST_GAIN 24'h400000
`define MCCE_AC_FS 24'h4CCCCD
`define MCCE_AC_EXTRA 27'h5
`define MCCE_DC_ONE 72'h000000_200000_000000
`endif

// File: hdl/mcce_pkg.sv
package mcce_pkg;
  typedef logic signed [23:0] mcce_word_t;
  typedef enum logic [2:0] {
    cmd_none, cmd_dc_offset, cmd_dc_gain, cmd_ac_offset, cmd_ac_gain
  } mcce_cmd_e;
  typedef enum logic [3:0] {
    st_idle, st_settle, st_acq, st_flush, st_load, st_mean, st_meandone,
    st_root, st_rootdone, st_quot, st_write, st_next
  } mcce_state_e;
  typedef struct packed {
    mcce_word_t dc_offset;
    logic [23:0] gain;
    mcce_word_t ac_offset;
  } mcce_corr_s;
  typedef struct packed {
    logic [3:0] rms_or;
    logic [3:0] inst_or;
    logic rdy;
  } mcce_flags_s;
endpackage

// File: hdl/mcce_engine.sv
`timescale 1ns/100ps
`include "mcce_map.svh"
// Behaviour
// R1 - Average exactly cycle-count samples in every calibration.
// R2 - DC offset and DC gain take at least count plus settling samples.
// R3 - AC offset takes at least six times count plus settling samples.
// R4 - Completion of any calibration sets the result ready flag.
// R5 - Overflow during calibration may also set overflow status bits.
// R6 - Every channel owns separate offset and gain registers.
// R7 - DC offset stores negated average DC level in the channel offset.
// R8 - AC offset stores negated residual RMS in the channel AC offset.
// R9 - AC gain stores 0.6 divided by measured RMS into the gain.
// R10 - DC gain stores reciprocal of average DC level into the gain.
// R11 - Over-range flags: instantaneous ones for DC, RMS ones for AC.
// R12 - AC gain full scale is 60 percent of input full scale.
// R13 - Host issues commands only while the device is active.
// R14 - Host loads unity gain before DC offset calibration.
// R15 - Host clears AC offsets before AC offset calibration.
// R16 - Host presets gain to unity or nominal over actual reference.
// R17 - Host applies DC reference for DC gain, filter off for DC.
// R18 - Host orders DC offset, gain, then AC offset, may repeat.
// R19 - Correction registers change only after averaging has fully ended. Host writes are taken any time but the engine's write cycle for that channel.
module mcce_engine (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic smp_valid,
  input wire mcce_pkg::mcce_word_t smp [4],
  output mcce_pkg::mcce_corr_s corr [4],
  output logic cal_busy,
  output logic irq
);
  mcce_pkg::mcce_state_e state;
  mcce_pkg::mcce_cmd_e cmd;
  mcce_pkg::mcce_flags_s status;
  mcce_pkg::mcce_flags_s mask;
  mcce_pkg::mcce_flags_s flag_set;
  logic [3:0] chmask;
  logic [1:0] ch;
  logic [23:0] cycles;
  logic [23:0] settle;
  logic [26:0] cnt;
  logic signed [47:0] acc [4];
  logic [71:0] sq [4];
  logic [71:0] num;
  logic [47:0] den;
  logic [71:0] quo;
  logic [48:0] rem;
  logic [6:0] it;
  logic [23:0] meas;

  function automatic logic [23:0] sat_to(input logic [71:0] q, input logic wide);
    logic [23:0] r;
    r = q[23:0];
    if (wide && |q[71:24]) begin
      r = 24'hFFFFFF;
    end else if (!wide && |q[71:23]) begin
      r = 24'h7FFFFF;
    end
    return r;
  endfunction

  // Bus decode
  wire logic apb_acc = psel & penable & ~pready;
  wire logic apb_done = psel & penable & pready;
  wire logic [1:0] pa_ch = paddr[3:2];
  wire logic sel_ctrl = paddr == `MCCE_OFF_CTRL;
  wire logic sel_cyc = paddr == `MCCE_OFF_CYCLES;
  wire logic sel_set = paddr == `MCCE_OFF_SETTLE;
  wire logic sel_stat = paddr == `MCCE_OFF_STATUS;
  wire logic sel_mask = paddr == `MCCE_OFF_MASK;
  wire logic sel_dcoff = (paddr & `MCCE_CHAN_FIELD) == `MCCE_OFF_DCOFF;
  wire logic sel_gain = (paddr & `MCCE_CHAN_FIELD) == `MCCE_OFF_GAIN;
  wire logic sel_acoff = (paddr & `MCCE_CHAN_FIELD) == `MCCE_OFF_ACOFF;
  wire logic addr_ok = sel_ctrl | sel_cyc | sel_set | sel_stat | sel_mask
                     | sel_dcoff | sel_gain | sel_acoff;
  wire logic wr_en = apb_done & pwrite & addr_ok;
  wire logic rd_status = apb_done & ~pwrite & sel_stat;
  wire logic [31:0] rd_mux =
      sel_ctrl ? {23'h0, 1'b0, chmask, 1'b0, cmd} :
      sel_cyc ? {8'h0, cycles} :
      sel_set ? {8'h0, settle} :
      sel_stat ? {15'h0, cal_busy, 7'h0, status} :
      sel_mask ? {23'h0, mask} :
      sel_dcoff ? {8'h0, corr[pa_ch].dc_offset} :
      sel_gain ? {8'h0, corr[pa_ch].gain} :
      sel_acoff ? {8'h0, corr[pa_ch].ac_offset} : 32'h0;
  wire mcce_pkg::mcce_cmd_e wr_cmd = mcce_pkg::mcce_cmd_e'(pwdata[`MCCE_CTRL_CMD_LSB +: 3]);
  wire logic cmd_ok = wr_cmd inside {mcce_pkg::cmd_dc_offset, mcce_pkg::cmd_dc_gain,
                                     mcce_pkg::cmd_ac_offset, mcce_pkg::cmd_ac_gain};
  // Commands only taken while idle; others are dropped
  wire logic go = wr_en & sel_ctrl & pwdata[`MCCE_CTRL_GO_BIT] & cmd_ok
                & (|pwdata[`MCCE_CTRL_CH_LSB +: 4]) & (state == mcce_pkg::st_idle);

  // Sequencer terms
  wire logic is_ac = cmd == mcce_pkg::cmd_ac_offset || cmd == mcce_pkg::cmd_ac_gain;
  wire logic is_gain = cmd == mcce_pkg::cmd_dc_gain || cmd == mcce_pkg::cmd_ac_gain;
  wire logic acq_end = state == mcce_pkg::st_acq && cnt == {3'h0, cycles};
  wire logic acq_take = state == mcce_pkg::st_acq && !acq_end && smp_valid;
  wire logic [26:0] flush_len = 27'(cycles) * `MCCE_AC_EXTRA;
  wire logic it_last = (state == mcce_pkg::st_root) ? it == 7'd23 : it == 7'd71;
  wire logic cal_done = state == mcce_pkg::st_next && ch == 2'd3;
  wire logic acc_sign = acc[ch][47];
  wire logic [47:0] acc_mag = acc_sign ? 48'h0 - acc[ch] : acc[ch];
  wire logic [23:0] mean_sat = sat_to(quo, 1'b0);
  wire logic mean_ovf = |quo[71:23];
  wire logic gain_ovf = |quo[71:24];
  wire logic [47:0] ac_num = 48'(corr[ch].gain) * 48'(`MCCE_AC_FS); // R9 R12
  wire logic [48:0] div_sh = {rem[47:0], num[71]};
  wire logic div_ge = div_sh >= {1'b0, den};
  wire logic [48:0] sqr_sh = {rem[46:0], num[71:70]};
  wire logic [48:0] sqr_try = {quo[46:0], 2'b01};
  wire logic sqr_ge = sqr_sh >= sqr_try;
  wire logic [23:0] wr_val =
      (cmd == mcce_pkg::cmd_dc_offset) ? (acc_sign ? meas : 24'h0 - meas) : // R7
      (cmd == mcce_pkg::cmd_ac_offset) ? 24'h0 - meas : // R8
      sat_to(quo, 1'b1); // R9 R10
  logic [3:0] smp_ext;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      smp_ext[i] = smp[i] == 24'h800000 || smp[i] == 24'h7FFFFF;
    end
  end
  // Mean of squares is not a result, so it never flags
  wire logic ovf_ev = (state == mcce_pkg::st_meandone && mean_ovf && !is_ac)
                    || (state == mcce_pkg::st_write && is_gain && gain_ovf);
  wire logic [3:0] chan_ev = ({4{acq_take}} & smp_ext) | ({4{ovf_ev}} & (4'h1 << ch));
  assign flag_set.inst_or = is_ac ? 4'h0 : chan_ev; // R5 R11
  assign flag_set.rms_or = is_ac ? chan_ev : 4'h0; // R5 R11
  assign flag_set.rdy = cal_done; // R4

  // Bus slave, one wait state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= apb_acc;
      pslverr <= apb_acc & ~addr_ok;
      if (apb_acc && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // Setup registers, status and interrupt
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cycles <= `MCCE_RST_CYCLES;
      settle <= `MCCE_RST_SETTLE;
      mask <= '0;
      status <= '0;
      irq <= 1'b0;
      cal_busy <= 1'b0;
    end else begin
      if (wr_en && sel_cyc && state == mcce_pkg::st_idle) begin
        cycles <= pwdata[23:0];
      end
      if (wr_en && sel_set && state == mcce_pkg::st_idle) begin
        settle <= pwdata[23:0];
      end
      if (wr_en && sel_mask) begin
        mask <= pwdata[8:0];
      end
      // Set beats the clear-on-read
      status <= (rd_status ? '0 : status) | flag_set; // R4
      irq <= |(status & mask);
      cal_busy <= state != mcce_pkg::st_idle || go;
    end
  end

  // Sequencer
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= mcce_pkg::st_idle;
      cmd <= mcce_pkg::cmd_none;
      chmask <= 4'h0;
      ch <= 2'd0;
      cnt <= 27'h0;
    end else begin
      case (state)
        mcce_pkg::st_idle: begin
          if (go) begin
            cmd <= wr_cmd;
            chmask <= pwdata[`MCCE_CTRL_CH_LSB +: 4];
            ch <= 2'd0;
            cnt <= 27'h0;
            state <= mcce_pkg::st_settle;
          end
        end
        mcce_pkg::st_settle: begin
          if (cnt == {3'h0, settle}) begin // R2 R3
            cnt <= 27'h0;
            state <= mcce_pkg::st_acq;
          end else if (smp_valid) begin
            cnt <= cnt + 27'h1;
          end
        end
        mcce_pkg::st_acq: begin
          if (acq_end) begin // R1
            cnt <= 27'h0;
            state <= (cmd == mcce_pkg::cmd_ac_offset) ? mcce_pkg::st_flush : mcce_pkg::st_load;
          end else if (smp_valid) begin
            cnt <= cnt + 27'h1;
          end
        end
        mcce_pkg::st_flush: begin
          if (cnt == flush_len) begin // R3
            state <= mcce_pkg::st_load;
          end else if (smp_valid) begin
            cnt <= cnt + 27'h1;
          end
        end
        mcce_pkg::st_load: begin
          state <= chmask[ch] ? mcce_pkg::st_mean : mcce_pkg::st_next;
        end
        mcce_pkg::st_mean: begin
          if (it_last) begin
            state <= mcce_pkg::st_meandone;
          end
        end
        mcce_pkg::st_meandone: begin
          state <= (cmd == mcce_pkg::cmd_dc_offset) ? mcce_pkg::st_write :
                   (cmd == mcce_pkg::cmd_dc_gain) ? mcce_pkg::st_quot : mcce_pkg::st_root;
        end
        mcce_pkg::st_root: begin
          if (it_last) begin
            state <= mcce_pkg::st_rootdone;
          end
        end
        mcce_pkg::st_rootdone: begin
          state <= (cmd == mcce_pkg::cmd_ac_offset) ? mcce_pkg::st_write : mcce_pkg::st_quot;
        end
        mcce_pkg::st_quot: begin
          if (it_last) begin
            state <= mcce_pkg::st_write;
          end
        end
        mcce_pkg::st_write: begin
          state <= mcce_pkg::st_next;
        end
        mcce_pkg::st_next: begin
          ch <= ch + 2'd1;
          state <= (ch == 2'd3) ? mcce_pkg::st_idle : mcce_pkg::st_load;
        end
        default: begin
          state <= mcce_pkg::st_idle;
        end
      endcase
    end
  end

  // Accumulators, all four channels in parallel
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (!rst_n || go) begin
        acc[i] <= 48'h0;
        sq[i] <= 72'h0;
      end else if (acq_take) begin // R1
        acc[i] <= acc[i] + 48'(smp[i]);
        sq[i] <= sq[i] + {24'h0, 48'(smp[i]) * 48'(smp[i])};
      end
    end
  end

  // Serial divider and square root
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      num <= 72'h0;
      den <= 48'h0;
      quo <= 72'h0;
      rem <= 49'h0;
      it <= 7'h0;
      meas <= 24'h0;
    end else begin
      case (state)
        mcce_pkg::st_load: begin
          num <= is_ac ? sq[ch] : {24'h0, acc_mag};
          den <= {24'h0, cycles};
          quo <= 72'h0;
          rem <= 49'h0;
          it <= 7'h0;
        end
        mcce_pkg::st_mean, mcce_pkg::st_quot: begin
          num <= {num[70:0], 1'b0};
          rem <= div_ge ? div_sh - {1'b0, den} : div_sh;
          quo <= {quo[70:0], div_ge};
          it <= it + 7'h1;
        end
        mcce_pkg::st_root: begin
          num <= {num[69:0], 2'b00};
          rem <= sqr_ge ? sqr_sh - sqr_try : sqr_sh;
          quo <= {quo[70:0], sqr_ge};
          it <= it + 7'h1;
        end
        mcce_pkg::st_meandone: begin
          meas <= mean_sat;
          num <= is_ac ? {quo[47:0], 24'h0} : `MCCE_DC_ONE; // R10
          den <= {24'h0, mean_sat};
          quo <= 72'h0;
          rem <= 49'h0;
          it <= 7'h0;
        end
        mcce_pkg::st_rootdone: begin
          meas <= quo[23:0];
          num <= {24'h0, ac_num}; // R9
          den <= {24'h0, quo[23:0]};
          quo <= 72'h0;
          rem <= 49'h0;
          it <= 7'h0;
        end
        default: begin
          it <= 7'h0;
        end
      endcase
    end
  end

  // Per-channel correction registers; the engine wins over a host write
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (!rst_n) begin
        corr[i] <= '{dc_offset: 24'h0, gain: `MCCE_RST_GAIN, ac_offset: 24'h0};
      end else if (state == mcce_pkg::st_write && ch == 2'(i)) begin // R6 R19
        case (cmd)
          mcce_pkg::cmd_dc_offset: corr[i].dc_offset <= wr_val; // R7
          mcce_pkg::cmd_ac_offset: corr[i].ac_offset <= wr_val; // R8
          mcce_pkg::cmd_dc_gain, mcce_pkg::cmd_ac_gain: corr[i].gain <= wr_val; // R9 R10
          default: corr[i] <= corr[i];
        endcase
      end else if (wr_en && pa_ch == 2'(i)) begin
        if (sel_dcoff) begin
          corr[i].dc_offset <= pwdata[23:0];
        end
        if (sel_gain) begin
          corr[i].gain <= pwdata[23:0];
        end
        if (sel_acoff) begin
          corr[i].ac_offset <= pwdata[23:0];
        end
      end
    end
  end

  // Checks
  logic [31:0] smp_seen;
  logic [26:0] acq_n;
  always_ff @(posedge core_clk) begin
    if (!rst_n || go) begin
      smp_seen <= 32'h0;
      acq_n <= 27'h0;
    end else begin
      smp_seen <= smp_seen + 32'(smp_valid);
      acq_n <= acq_n + 27'(smp_valid && state == mcce_pkg::st_acq && !acq_end);
    end
  end
  wire logic [31:0] dc_min = 32'(cycles) + 32'(settle);
  wire logic [31:0] ac_min = 32'(cycles) * 32'h6 + 32'(settle);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_avg_sample_count: assert property (acq_end |-> acq_n == 27'(cycles)) // R1
    else $error("averaged sample count differs from cycle count");
  a_dc_min_time: assert property ( // R2
    (acq_end && !is_ac) |-> smp_seen >= dc_min)
    else $error("DC calibration finished averaging too early");
  a_ac_min_time: assert property ( // R3
    (state == mcce_pkg::st_flush && cnt == flush_len) |-> smp_seen >= ac_min)
    else $error("AC offset calibration finished too early");
  a_done_sets_ready: assert property (cal_done |=> status.rdy ##1 cal_busy == 1'b0) // R4
    else $error("result ready flag not set at completion");
  a_other_chan_kept: assert property ( // R6
    (state == mcce_pkg::st_write && ch != 2'd0 && !wr_en) |=> $stable(corr[0]))
    else $error("write to one channel disturbed channel zero");
  a_dc_offset_sign: assert property ( // R7
    (state == mcce_pkg::st_write && cmd == mcce_pkg::cmd_dc_offset && ch == 2'd2
     && meas != 24'h0) |=> corr[2].dc_offset[23] == !$past(acc_sign))
    else $error("DC offset not the negated average");
  a_inst_over_range: assert property ( // R11
    (acq_take && !is_ac && smp_ext[2]) |=> status.inst_or[2] && !status.rms_or[2])
    else $error("instantaneous over-range not flagged");
  a_corr_hold_acq: assert property ( // R19
    (state inside {mcce_pkg::st_settle, mcce_pkg::st_acq, mcce_pkg::st_flush} && !wr_en)
    |=> $stable(corr[3]))
    else $error("correction changed before averaging ended");
  c_dc_offset_done: cover property (cal_done && cmd == mcce_pkg::cmd_dc_offset);
  c_ac_gain_done: cover property (cal_done && cmd == mcce_pkg::cmd_ac_gain);
  c_gain_overflow: cover property (ovf_ev && is_gain);
endmodule

// File: tb/mcce_smp_src.sv
`timescale 1ns/100ps
module mcce_smp_src #(
  parameter int PERIOD = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire mcce_pkg::mcce_word_t level [4],
  output logic smp_valid,
  output mcce_pkg::mcce_word_t smp [4]
);
  int cnt;
  logic wrap;
  assign wrap = (cnt == PERIOD - 1);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt <= 0;
      smp_valid <= 1'b0;
    end else begin
      cnt <= wrap ? 0 : cnt + 1;
      smp_valid <= wrap;
    end
  end
  // Steady reference level; words outside the strobe are inverted garbage
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      smp[i] = smp_valid ? level[i] : ~level[i];
    end
  end
endmodule

// File: tb/mcce_engine_test.sv
`timescale 1ns/100ps
`include "mcce_map.svh"
module mcce_engine_test;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic smp_valid;
  mcce_pkg::mcce_word_t smp [4];
  mcce_pkg::mcce_word_t lvl [4] = '{default: 24'h000000};
  mcce_pkg::mcce_corr_s corr_w [4];
  mcce_pkg::mcce_corr_s snap [4];
  logic cal_busy;
  logic irq;
  int error_cnt = 0;
  int samples_checked = 0;
  int smp_tot = 0;
  int base = 0;
  logic [31:0] rd;
  logic er;

  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) if (smp_valid === 1'b1) smp_tot <= smp_tot + 1;

  mcce_smp_src #(.PERIOD(8)) src (.core_clk(core_clk), .rst_n(rst_n), .level(lvl),
    .smp_valid(smp_valid), .smp(smp));
  mcce_engine uut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .smp_valid(smp_valid), .smp(smp), .corr(corr_w),
    .cal_busy(cal_busy), .irq(irq));

  task automatic tally_and_finish();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
    samples_checked++;
    if ((^got) === 1'bx || got > exp + tol || got + tol < exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cal_go(input logic [2:0] cmd, input logic [3:0] chs);
    base = smp_tot;
    snap = corr_w;
    apb(1'b1, `MCCE_OFF_CTRL, 32'h100 | {24'h0, chs, 1'b0, cmd});
  endtask

  task automatic cal_end(input int min_smp, input logic [8:0] st);
    while (irq !== 1'b1) begin
      @(posedge core_clk);
      if (smp_tot - base < min_smp && corr_w != snap) chk(32'h1, 32'h0, 0);
    end
    chk(32'(smp_tot - base >= min_smp), 32'h1, 0);
    apb(1'b0, `MCCE_OFF_STATUS, 32'h0);
    chk({23'h0, rd[8:0]}, {23'h0, st}, 0);
    apb(1'b0, `MCCE_OFF_STATUS, 32'h0);
    chk({23'h0, rd[8:0]}, 32'h0, 0);
    chk({31'h0, irq}, 32'h0, 0);
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, `MCCE_OFF_CYCLES, 32'h0);
    chk(rd, 32'h00000FA0, 0);
    apb(1'b0, `MCCE_OFF_SETTLE, 32'h0);
    chk(rd, 32'h00000080, 0);
    apb(1'b0, `MCCE_OFF_GAIN + 12'h004, 32'h0);
    chk(rd, 32'h00400000, 0);
    apb(1'b0, 12'h0FC, 32'h0);
    chk({rd[30:0], er}, 32'h00000001, 0);
    apb(1'b1, `MCCE_OFF_CYCLES, 32'h4);
    apb(1'b1, `MCCE_OFF_SETTLE, 32'h2);
    apb(1'b1, `MCCE_OFF_MASK, 32'h1);
    apb(1'b1, `MCCE_OFF_GAIN, 32'h00400000);
    apb(1'b1, `MCCE_OFF_GAIN + 12'h008, 32'h00400000);
    lvl <= '{24'h001000, 24'h002000, 24'h000800, 24'h003000};
    cal_go(3'd1, 4'b0101);
    apb(1'b1, `MCCE_OFF_CYCLES, 32'h9);
    chk({31'h0, cal_busy}, 32'h1, 0);
    apb(1'b1, `MCCE_OFF_CTRL, 32'h000001F3);
    cal_end(6, 9'h001);
    chk({8'h0, corr_w[0].dc_offset}, 32'h00FFF000, 0);
    chk({8'h0, corr_w[2].dc_offset}, 32'h00FFF800, 0);
    chk({8'h0, corr_w[1].dc_offset}, 32'h0, 0);
    chk({8'h0, corr_w[3].ac_offset}, 32'h0, 0);
    apb(1'b0, `MCCE_OFF_CYCLES, 32'h0);
    chk(rd, 32'h4, 0);
    lvl[1] <= 24'h400000;
    cal_go(3'd2, 4'b0010);
    cal_end(6, 9'h001);
    chk({8'h0, corr_w[1].gain}, 32'h00800000, 4);
    chk({8'h0, corr_w[0].gain}, 32'h00400000, 0);
    apb(1'b1, `MCCE_OFF_GAIN + 12'h00C, 32'h00400000);
    lvl[3] <= 24'h266666;
    cal_go(3'd4, 4'b1000);
    cal_end(6, 9'h001);
    chk({8'h0, corr_w[3].gain}, 32'h00800000, 8);
    apb(1'b1, `MCCE_OFF_ACOFF, 32'h0);
    lvl[0] <= 24'h000400;
    cal_go(3'd3, 4'b0001);
    cal_end(26, 9'h001);
    chk({8'h0, corr_w[0].ac_offset}, 32'h00FFFC00, 2);
    lvl[2] <= 24'h7FFFFF;
    cal_go(3'd1, 4'b0100);
    cal_end(6, 9'h009);
    cal_go(3'd3, 4'b0100);
    cal_end(26, 9'h081);
    apb(1'b1, `MCCE_OFF_CTRL, 32'h00000110);
    repeat (3) @(posedge core_clk);
    chk({31'h0, cal_busy}, 32'h0, 0);
    tally_and_finish();
  end
endmodule
